// *** core/nfcirq_status.sv ***
// nfcirq_status: event status flags, masks and interrupt request of the nfc front end,
// reached over an ahb-lite slave with zero wait states.
// assumes event inputs are one-cycle pulses or levels synchronous to hclk; single word access.
//
// Functional notes
// - reading timer or target status clears it
// - main status read clears error/wake-up status
// - flag oscillator stable after enable, bit 7
// - receiving, above 300 fifo bytes sets level
// - transmitting, below 200 fifo bytes sets level
// - rx start, rx end, tx end, collision flags
// - flag reception restart after disturbance frame dropped
// - flag command done and timer expiries
// - flag external field rise and fall
// - flag guard time elapsed after field on
// - flag initiator bit rate recognised in target
// - flag parity, soft framing, hard framing errors
// - wake-up timeout flag only if option chosen
// - flag amplitude and phase wake-up deltas
// - flag second field-on wait timer event
// - flag four time slot numbers left
// - flag p2p field on without collision
// - flag automatic anticollision response, host needed
// - flag automatic sensf response sent
// - flag target active star and active states
// - set mask bit suppresses that event's interrupt
`timescale 1ns/10ps

module nfcirq_status #(
  parameter int COUNT_W = 10 // width of the fifo byte count
) (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // oscillator and fifo
  output logic                    osc_enable,
  input  wire logic               osc_stable,
  input  wire logic [COUNT_W-1:0] fifo_count,
  input  wire logic               rx_active,
  input  wire logic               tx_active,
  // framing events
  input  wire logic               rx_start,
  input  wire logic               rx_end,
  input  wire logic               tx_end,
  input  wire logic               bit_collision,
  input  wire logic               rx_restart,
  // timer and field events
  input  wire logic               cmd_done,
  input  wire logic               nrt_expired,
  input  wire logic               gpt_expired,
  input  wire logic               ext_field_on,
  input  wire logic               ext_field_off,
  input  wire logic               ca_collision,
  input  wire logic               ca_guard_done,
  input  wire logic               bitrate_found,
  // error and wake-up events
  input  wire logic               crc_error,
  input  wire logic               parity_error,
  input  wire logic               soft_framing_error,
  input  wire logic               hard_framing_error,
  input  wire logic               wakeup_running,
  input  wire logic               wakeup_timeout,
  input  wire logic               amplitude_delta,
  input  wire logic               phase_delta,
  // passive-target events
  input  wire logic               second_field_wait,
  input  wire logic               slot_reserve_low,
  input  wire logic               p2p_field_on,
  input  wire logic               auto_anticoll_sent,
  input  wire logic               sensf_resp_sent,
  input  wire logic               target_active_star,
  input  wire logic               target_active,
  // interrupt request
  output logic                    irq
);

  // the count must be able to show a full fifo; a narrower one is refused at elaboration
  // because a count that wraps would fake the transmit level and hide the receive level
  if ((1 << COUNT_W) <= nfcirq_pkg::FIFO_DEPTH_BYTES) begin : g_count_check
    $error("COUNT_W too small for the fifo depth");
  end

  // whole state of the block
  typedef struct packed {
    logic [3:0][7:0] mask;     // 0 main, 1 timer, 2 error, 3 target
    logic [3:0][7:0] status;   // sticky event flags, same order
    logic [7:0]      cfg;      // configuration bits
    logic            osc_prev; // oscillator stable, last cycle
    logic            lvl_prev; // water level condition, last cycle
    logic            pend_wr;  // write data phase pending
    logic [5:0]      wr_idx;   // index of the pending write
    logic [31:0]     rdata;    // read data for the data phase
    logic            irq;      // interrupt request
  } nfcirq_state_t;

  nfcirq_state_t cur;          // registered state
  nfcirq_state_t next_cur;     // next state

  logic            take;       // transfer taken in its address phase
  logic            rd_take;    // read taken
  logic [5:0]      rd_idx;     // word index of the access
  logic            lvl_cond;   // fifo water level reached
  logic [3:0][7:0] set_vec;    // event sets this cycle
  logic [3:0][7:0] clr_vec;    // read clears this cycle
  logic [3:0][7:0] valid_bits; // implemented bits per group
  logic            pending;    // any unmasked flag in the current state

  assign valid_bits = {nfcirq_pkg::PT_BITS, nfcirq_pkg::ERR_BITS,
                       nfcirq_pkg::TMR_BITS, nfcirq_pkg::MAIN_BITS};
  assign take     = hsel & htrans[1] & hready;
  assign rd_take  = take & ~hwrite;
  assign rd_idx   = haddr[7:2];

  // water level: the direction of transfer picks the threshold
  // a count between the two levels flags nothing in either direction
  assign lvl_cond = (rx_active & (int'(fifo_count) > nfcirq_pkg::RX_LEVEL_BYTES))
                  | (tx_active & (int'(fifo_count) < nfcirq_pkg::TX_LEVEL_BYTES));

  // event set vectors; flags are caught on the first cycle of their condition
  // a plain source held high keeps setting its flag; oscillator and water level set only on their rising edge
  always_comb begin
    set_vec[0] = {osc_stable & ~cur.osc_prev & cur.cfg[nfcirq_pkg::CFG_OSC_EN_POS],
                  lvl_cond & ~cur.lvl_prev,
                  rx_start, rx_end, tx_end, bit_collision,
                  rx_restart,
                  1'b0};
    set_vec[1] = {cmd_done, nrt_expired, gpt_expired,
                  ext_field_on, ext_field_off,
                  ca_collision,
                  ca_guard_done,
                  bitrate_found};
    set_vec[2] = {crc_error, parity_error, soft_framing_error, hard_framing_error,
                  wakeup_running & wakeup_timeout
                    & cur.cfg[nfcirq_pkg::CFG_WU_EVERY_POS],
                  amplitude_delta, phase_delta,
                  1'b0};
    set_vec[3] = {second_field_wait,
                  slot_reserve_low,
                  p2p_field_on,
                  auto_anticoll_sent,
                  sensf_resp_sent,
                  1'b0,
                  target_active_star, target_active};
  end

  // read side effects: each status read clears itself, a main read clears errors too
  always_comb begin
    clr_vec = '0;
    if (rd_take && rd_idx == nfcirq_pkg::STAT_MAIN_IDX) begin
      clr_vec[0] = 8'hff;
      clr_vec[2] = 8'hff;
    end else if (rd_take && rd_idx == nfcirq_pkg::STAT_TMR_IDX) begin
      clr_vec[1] = 8'hff;
    end else if (rd_take && rd_idx == nfcirq_pkg::STAT_ERR_IDX) begin
      clr_vec[2] = 8'hff;
    end else if (rd_take && rd_idx == nfcirq_pkg::STAT_PT_IDX) begin
      clr_vec[3] = 8'hff;
    end
  end

  // interrupt condition of the current flags; masked events never reach irq
  always_comb begin
    pending = 1'b0;
    for (int i = 0; i < 4; i++) begin
      pending = pending | (|(cur.status[i] & ~cur.mask[i]));
    end
  end

  // next state: bus writes, flag updates, read data and irq
  always_comb begin
    next_cur          = cur;
    next_cur.osc_prev = osc_stable;
    next_cur.lvl_prev = lvl_cond;
    // write data phase: hwdata belongs to the address taken one transfer back
    if (cur.pend_wr) begin
      if (cur.wr_idx == nfcirq_pkg::MASK_MAIN_IDX) begin
        next_cur.mask[0] = hwdata[7:0] & nfcirq_pkg::MAIN_BITS;
      end else if (cur.wr_idx == nfcirq_pkg::MASK_TMR_IDX) begin
        next_cur.mask[1] = hwdata[7:0] & nfcirq_pkg::TMR_BITS;
      end else if (cur.wr_idx == nfcirq_pkg::MASK_ERR_IDX) begin
        next_cur.mask[2] = hwdata[7:0] & nfcirq_pkg::ERR_BITS;
      end else if (cur.wr_idx == nfcirq_pkg::MASK_PT_IDX) begin
        next_cur.mask[3] = hwdata[7:0] & nfcirq_pkg::PT_BITS;
      end else if (cur.wr_idx == nfcirq_pkg::CFG_IDX) begin
        next_cur.cfg = hwdata[7:0] & nfcirq_pkg::CFG_BITS;
      end
      // status writes and unmapped writes are ignored
    end
    // address phase bookkeeping
    next_cur.pend_wr = take & hwrite;
    if (take) begin
      next_cur.wr_idx = rd_idx;
    end
    // read data: taken from post-write values so a write then read sees the new word
    next_cur.rdata = 32'h0000_0000;
    if (rd_take) begin
      if (rd_idx == nfcirq_pkg::MASK_MAIN_IDX) begin
        next_cur.rdata[7:0] = next_cur.mask[0];
      end else if (rd_idx == nfcirq_pkg::MASK_TMR_IDX) begin
        next_cur.rdata[7:0] = next_cur.mask[1];
      end else if (rd_idx == nfcirq_pkg::MASK_ERR_IDX) begin
        next_cur.rdata[7:0] = next_cur.mask[2];
      end else if (rd_idx == nfcirq_pkg::MASK_PT_IDX) begin
        next_cur.rdata[7:0] = next_cur.mask[3];
      end else if (rd_idx == nfcirq_pkg::STAT_MAIN_IDX) begin
        next_cur.rdata[7:0] = cur.status[0];
      end else if (rd_idx == nfcirq_pkg::STAT_TMR_IDX) begin
        next_cur.rdata[7:0] = cur.status[1];
      end else if (rd_idx == nfcirq_pkg::STAT_ERR_IDX) begin
        next_cur.rdata[7:0] = cur.status[2];
      end else if (rd_idx == nfcirq_pkg::STAT_PT_IDX) begin
        next_cur.rdata[7:0] = cur.status[3];
      end else if (rd_idx == nfcirq_pkg::CFG_IDX) begin
        next_cur.rdata[7:0] = next_cur.cfg;
      end
      // unmapped addresses read zero
    end
    // flags: an event in the clearing cycle survives the clear
    for (int i = 0; i < 4; i++) begin
      next_cur.status[i] = ((cur.status[i] & ~clr_vec[i]) | set_vec[i]) & valid_bits[i];
    end
    // irq follows the flags one cycle later, released once all unmasked flags are gone
    next_cur.irq = pending;
  end

  // state register
  // only constants in the reset branch; everything else arrives through next_cur
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur.mask     <= {4{nfcirq_pkg::MASK_RST}};
      cur.status   <= {4{nfcirq_pkg::STAT_RST}};
      cur.cfg      <= nfcirq_pkg::CFG_RST;
      cur.osc_prev <= 1'b0;
      cur.lvl_prev <= 1'b0;
      cur.pend_wr  <= 1'b0;
      cur.wr_idx   <= 6'h00;
      cur.rdata    <= 32'h0000_0000;
      cur.irq      <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // hrdata, irq and osc_enable straight from flops; the slave never stalls and never errs
  // hreadyout and hresp are tied, so the master never sees a wait state
  assign hrdata     = cur.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign irq        = cur.irq;
  assign osc_enable = cur.cfg[nfcirq_pkg::CFG_OSC_EN_POS];

  // checks on the block's own behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_tmr_read_clear: assert property (
    (rd_take && rd_idx == nfcirq_pkg::STAT_TMR_IDX && set_vec[1] == 8'h00)
      |=> (cur.status[1] == 8'h00 && hrdata[7:0] == $past(cur.status[1])))
    else $error("timer status not cleared by its read");

  a_main_clears_err: assert property (
    (rd_take && rd_idx == nfcirq_pkg::STAT_MAIN_IDX && set_vec[2] == 8'h00)
      |=> cur.status[2] == 8'h00)
    else $error("error status survived a main status read");

  a_osc_flag_set: assert property (
    ($rose(osc_stable) && osc_enable) |=> cur.status[0][nfcirq_pkg::MAIN_OSC_POS])
    else $error("oscillator flag missing");

  a_rx_level_set: assert property (
    (rx_active && !tx_active && int'(fifo_count) > nfcirq_pkg::RX_LEVEL_BYTES && !cur.lvl_prev)
      |=> cur.status[0][nfcirq_pkg::MAIN_LEVEL_POS])
    else $error("receive water level not flagged");

  a_tx_level_set: assert property (
    (tx_active && !rx_active && int'(fifo_count) < nfcirq_pkg::TX_LEVEL_BYTES && !cur.lvl_prev)
      |=> cur.status[0][nfcirq_pkg::MAIN_LEVEL_POS])
    else $error("transmit water level not flagged");

  a_wakeup_gated: assert property (
    (wakeup_timeout && wakeup_running && !cur.cfg[nfcirq_pkg::CFG_WU_EVERY_POS]
      && !cur.status[2][nfcirq_pkg::ERR_WU_TIMEOUT_POS])
      |=> !cur.status[2][nfcirq_pkg::ERR_WU_TIMEOUT_POS])
    else $error("wake-up timeout flagged without the option");

  a_target_active: assert property (
    (target_active && target_active_star) |=> (cur.status[3][1:0] == 2'b11))
    else $error("target activation flags missing");

  a_irq_follows: assert property (
    ##1 irq == $past((cur.status & ~cur.mask) != 32'h0000_0000))
    else $error("irq does not follow unmasked flags");

  a_mask_blocks: assert property (
    (cur.mask == {nfcirq_pkg::PT_BITS, nfcirq_pkg::ERR_BITS,
                  nfcirq_pkg::TMR_BITS, nfcirq_pkg::MAIN_BITS}) [*2] |-> !irq)
    else $error("irq raised with every event masked");

  // per-source capture: every event (the wake-up timeout and the oscillator rise only with their options) shows in its flag at the next edge, read or not,
  // because a set always beats a clear falling in the same cycle
  a_pt_read_clear: assert property (
    (rd_take && rd_idx == nfcirq_pkg::STAT_PT_IDX && set_vec[3] == 8'h00)
      |=> cur.status[3] == 8'h00)
    else $error("target status not cleared by its read");

  a_main_read_clear: assert property (
    (rd_take && rd_idx == nfcirq_pkg::STAT_MAIN_IDX && set_vec[0] == 8'h00)
      |=> cur.status[0] == 8'h00)
    else $error("main status not cleared by its read");

  a_main_events: assert property (
    ##1 (($past({rx_start, rx_end, tx_end, bit_collision}) & ~cur.status[0][5:2]) == 4'h0))
    else $error("framing event not flagged");

  a_restart_flag: assert property (
    rx_restart |=> cur.status[0][1])
    else $error("reception restart not flagged");

  a_timer_events: assert property (
    ##1 (($past({cmd_done, nrt_expired, gpt_expired}) & ~cur.status[1][7:5]) == 3'h0))
    else $error("command or timer event not flagged");

  a_field_events: assert property (
    ##1 (($past({ext_field_on, ext_field_off}) & ~cur.status[1][4:3]) == 2'h0))
    else $error("external field change not flagged");

  a_guard_flag: assert property (
    ca_guard_done |=> cur.status[1][1])
    else $error("guard time expiry not flagged");

  a_bitrate_flag: assert property (
    bitrate_found |=> cur.status[1][0])
    else $error("initiator bit rate not flagged");

  a_error_events: assert property (
    ##1 (($past({parity_error, soft_framing_error, hard_framing_error})
          & ~cur.status[2][6:4]) == 3'h0))
    else $error("receive error not flagged");

  a_wakeup_every: assert property (
    (wakeup_timeout && wakeup_running && cur.cfg[nfcirq_pkg::CFG_WU_EVERY_POS])
      |=> cur.status[2][nfcirq_pkg::ERR_WU_TIMEOUT_POS])
    else $error("wake-up timeout not flagged");

  a_wakeup_deltas: assert property (
    ##1 (($past({amplitude_delta, phase_delta}) & ~cur.status[2][2:1]) == 2'h0))
    else $error("wake-up delta not flagged");

  a_wait_timer_flag: assert property (
    second_field_wait |=> cur.status[3][7])
    else $error("field-on wait timer not flagged");

  a_slot_low_flag: assert property (
    slot_reserve_low |=> cur.status[3][6])
    else $error("slot reserve low not flagged");

  a_p2p_field_flag: assert property (
    p2p_field_on |=> cur.status[3][5])
    else $error("peer field on not flagged");

  a_auto_resp_flag: assert property (
    auto_anticoll_sent |=> cur.status[3][4])
    else $error("automatic response not flagged");

  a_sensf_flag: assert property (
    sensf_resp_sent |=> cur.status[3][3])
    else $error("sensf response not flagged");

endmodule

// *** core/nfcirq_pkg.sv ***
// nfcirq_pkg: register map, field layout and thresholds of the nfc event status block.
// assumes a 32-bit ahb-lite bus; each register takes one aligned word at four times its index.
package nfcirq_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [5:0] MASK_MAIN_IDX  = 6'h16; // mask of main event status
  localparam logic [5:0] MASK_TMR_IDX   = 6'h17; // mask of timer/field event status
  localparam logic [5:0] MASK_ERR_IDX   = 6'h18; // mask of error/wake-up event status
  localparam logic [5:0] MASK_PT_IDX    = 6'h19; // mask of passive-target event status
  localparam logic [5:0] STAT_MAIN_IDX  = 6'h1a; // main_event_status
  localparam logic [5:0] STAT_TMR_IDX   = 6'h1b; // timer_field_event_status
  localparam logic [5:0] STAT_ERR_IDX   = 6'h1c; // error_wakeup_event_status
  localparam logic [5:0] STAT_PT_IDX    = 6'h1d; // passive_target_event_status
  localparam logic [5:0] CFG_IDX        = 6'h30; // block configuration

  // reset values
  localparam logic [7:0] MASK_RST       = 8'h00; // all events unmasked
  localparam logic [7:0] STAT_RST       = 8'h00; // no event pending
  localparam logic [7:0] CFG_RST        = 8'h00; // oscillator off, no wake-up timeout irq

  // implemented bits of each register group; the rest are reserved and read zero
  localparam logic [7:0] MAIN_BITS      = 8'hfe;
  localparam logic [7:0] TMR_BITS       = 8'hff;
  localparam logic [7:0] ERR_BITS       = 8'hfe;
  localparam logic [7:0] PT_BITS        = 8'hfb;
  localparam logic [7:0] CFG_BITS       = 8'h03;

  // configuration fields
  localparam int CFG_OSC_EN_POS         = 0; // starts the crystal oscillator
  localparam int CFG_WU_EVERY_POS       = 1; // wake-up irq at every timeout

  // main status field positions
  localparam int MAIN_OSC_POS           = 7;
  localparam int MAIN_LEVEL_POS         = 6;
  // error/wake-up status field positions
  localparam int ERR_WU_TIMEOUT_POS     = 3;

  // fifo water levels in bytes
  localparam int RX_LEVEL_BYTES         = 300; // receive: flag above this
  localparam int TX_LEVEL_BYTES         = 200; // transmit: flag below this
  localparam int FIFO_DEPTH_BYTES       = 512;

endpackage

// *** verif/nfcirq_host.sv ***
// nfcirq_host: behavioural ahb-lite master standing for the host microcontroller.
// assumes one slave whose hreadyout is the bus hready; single whole-word transfers only.
`timescale 1ns/10ps

module nfcirq_host (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // command from the bench, req is a one-cycle pulse
  input  wire logic        req,
  input  wire logic [31:0] req_addr,
  input  wire logic        req_write,
  input  wire logic [31:0] req_wdata,
  output logic             done,
  output logic [31:0]      rdata,
  // ahb-lite master side
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [1:0] ph; // 0 idle, 1 address phase, 2 data phase

  // one transfer at a time; every signal changes just after a rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph, hsel, haddr, htrans, hwrite, done, rdata, hwdata} <= '0;
      hsize <= 3'h2;
    end else begin
      done <= 1'b0;
      case (ph)
        2'd0: begin
          // idle: released write data toggles so a stale value is never mistaken
          hwdata <= ~hwdata;
          if (req) begin
            hsel   <= 1'b1;
            haddr  <= req_addr;
            hwrite <= req_write;
            htrans <= 2'b10;
            ph     <= 2'd1;
          end
        end
        2'd1: if (hready) begin
          // address taken: go idle, put data on for writes only
          htrans <= 2'b00;
          hwdata <= req_write ? req_wdata : ~hwdata;
          ph     <= 2'd2;
        end
        default: if (hready) begin
          // read data is taken at the edge that ends the data phase
          rdata <= hrdata;
          done  <= 1'b1;
          hsel  <= 1'b0;
          ph    <= 2'd0;
        end
      endcase
    end
  end
endmodule

// *** verif/test_nfcirq_status.sv ***
// test_nfcirq_status: self-checking bench of the event status block against an integer model.
// assumes the host model in nfcirq_host.sv and zero-wait ahb-lite answers from the slave.
`timescale 1ns/10ps

module test_nfcirq_status;
  logic        hclk = 1'b0, hresetn = 1'b0, req = 1'b0, req_write = 1'b0;
  logic [31:0] req_addr = '0, req_wdata = '0, rdata, haddr, hwdata, hrdata;
  logic        done, hsel, hwrite, hreadyout, hresp, osc_enable, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        osc_stable = 1'b0, rx_active = 1'b0, tx_active = 1'b0, wakeup_running = 1'b0;
  logic [9:0]  fifo_count = '0;
  logic [7:0]  ev [4] = '{8'h00, 8'h00, 8'h00, 8'h00}; // event pulses per register group
  logic [7:0]  evb [4] = '{8'h3e, 8'hff, 8'hfe, 8'hfb}; // bits set by plain event pulses
  logic [7:0]  rb [4] = '{nfcirq_pkg::MAIN_BITS, nfcirq_pkg::TMR_BITS,
                          nfcirq_pkg::ERR_BITS, nfcirq_pkg::PT_BITS}; // readable bits
  int          err_total = 0, samples_checked = 0, seed = 32'heefa, st [4], mk [4];

  always #2 hclk = ~hclk; // 250 mhz

  nfcirq_host u_host (.hclk(hclk), .hresetn(hresetn), .req(req), .req_addr(req_addr),
    .req_write(req_write), .req_wdata(req_wdata), .done(done), .rdata(rdata), .hready(hreadyout),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  nfcirq_status u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_enable(osc_enable),
    .osc_stable(osc_stable), .fifo_count(fifo_count), .rx_active(rx_active),
    .tx_active(tx_active), .rx_start(ev[0][5]), .rx_end(ev[0][4]), .tx_end(ev[0][3]),
    .bit_collision(ev[0][2]), .rx_restart(ev[0][1]), .cmd_done(ev[1][7]),
    .nrt_expired(ev[1][6]), .gpt_expired(ev[1][5]), .ext_field_on(ev[1][4]),
    .ext_field_off(ev[1][3]), .ca_collision(ev[1][2]), .ca_guard_done(ev[1][1]),
    .bitrate_found(ev[1][0]), .crc_error(ev[2][7]), .parity_error(ev[2][6]),
    .soft_framing_error(ev[2][5]), .hard_framing_error(ev[2][4]),
    .wakeup_running(wakeup_running), .wakeup_timeout(ev[2][3]), .amplitude_delta(ev[2][2]),
    .phase_delta(ev[2][1]), .second_field_wait(ev[3][7]), .slot_reserve_low(ev[3][6]),
    .p2p_field_on(ev[3][5]), .auto_anticoll_sent(ev[3][4]), .sensf_resp_sent(ev[3][3]),
    .target_active_star(ev[3][1]), .target_active(ev[3][0]), .irq(irq));

  // verdict and end of run, shared by the main sequence and the watchdog
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // compare of a register read
  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: register read %h, model %h", $time, got, exp);
    end
  endtask

  // compare of a single pin
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: pin %b, model %b", $time, got, exp);
    end
  endtask

  // one bus transfer through the host model; waits for completion under a bound
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    req       <= 1'b1;
    req_addr  <= a;
    req_write <= w;
    req_wdata <= d;
    @(posedge hclk);
    req <= 1'b0;
    repeat (50) begin
      #1;
      if (done === 1'b1) break;
      @(posedge hclk);
    end
    chk_pin(done, 1'b1);
    chk_pin(hresp, 1'b0);
    chk_pin(hreadyout, 1'b1);
    q = rdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk_reg(exp, q);
  endtask

  // status read against the model, then the model applies the read-clear side effect
  task automatic rd_stat(input int g);
    rd(32'(32'h68 + 4 * g), 32'(st[g] & rb[g]));
    st[g] = 0;
    if (g == 0) st[2] = 0; // main read also empties error/wake-up
  endtask

  // one-cycle event pulse on a register group
  task automatic pulse(input int g, input logic [7:0] pat);
    @(posedge hclk);
    ev[g] <= pat;
    @(posedge hclk);
    ev[g] <= 8'h00;
    st[g] |= pat;
  endtask

  // model of the request line: any unmasked pending flag
  function automatic logic exp_irq();
    int r;
    r = 0;
    for (int g = 0; g < 4; g++) r |= st[g] & ~mk[g] & rb[g];
    return r != 0;
  endfunction

  task automatic chk_irq();
    repeat (3) @(posedge hclk);
    #1;
    chk_pin(irq, exp_irq());
  endtask

  // fifo water level case: enter a direction with a count, flag expected or not
  task automatic level(input logic rxa, input logic txa, input logic [9:0] cnt, input logic f);
    @(posedge hclk);
    fifo_count <= cnt;
    rx_active  <= rxa;
    tx_active  <= txa;
    repeat (3) @(posedge hclk);
    rx_active <= 1'b0;
    tx_active <= 1'b0;
    if (f) st[0] |= 8'h40;
    rd_stat(0);
  endtask

  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    end_sim();
  end

  // main sequence
  initial begin
    for (int g = 0; g < 4; g++) begin
      st[g] = 0;
      mk[g] = 0;
    end
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 32'h58; a <= 32'h74; a += 4) rd(32'(a), 32'h0);
    rd(32'hc0, 32'h0);
    rd(32'h100, 32'h0);                 // unmapped reads zero
    wr(32'h6c, 32'hff);                 // status is read only, write ignored
    rd_stat(1);
    wr(32'hc0, 32'h2);                  // interrupt at every wake-up timeout
    @(posedge hclk);
    wakeup_running <= 1'b1;
    // random masks and events; status is read promptly after each burst
    repeat (6) begin
      for (int g = 0; g < 4; g++) begin
        mk[g] = $random(seed) & 8'hff;
        wr(32'(32'h58 + 4 * g), 32'(mk[g]));
        rd(32'(32'h58 + 4 * g), 32'(mk[g] & rb[g]));
        pulse(g, 8'($random(seed)) & evb[g]);
        chk_irq();
        rd_stat(g);
        rd_stat(g);
        chk_irq();
      end
    end
    // every source masked: flags still latch but the request line stays low
    for (int g = 0; g < 4; g++) begin
      mk[g] = 8'hff;
      wr(32'(32'h58 + 4 * g), 32'hff);
    end
    pulse(1, 8'hff);
    chk_irq();
    rd_stat(1);
    pulse(2, 8'hf6);
    rd_stat(0);
    rd_stat(2);
    wr(32'hc0, 32'h0);                  // every-timeout option off
    pulse(2, 8'h08);
    st[2] = 0;
    rd_stat(2);
    wr(32'hc0, 32'h1);                  // start the oscillator
    chk_pin(osc_enable, 1'b1);
    @(posedge hclk);
    osc_stable <= 1'b1;
    repeat (3) @(posedge hclk);
    st[0] |= 8'h80;
    rd_stat(0);
    chk_irq();
    level(1'b1, 1'b0, 10'd301, 1'b1);
    level(1'b1, 1'b0, 10'd300, 1'b0);
    level(1'b0, 1'b1, 10'd199, 1'b1);
    level(1'b0, 1'b1, 10'd200, 1'b0);
    level(1'b0, 1'b0, 10'd5, 1'b0);
    end_sim();
  end
endmodule
